// [acu_axis_model.sv]
`timescale 1ns/1ps
// stand-in for the axis counters and the pulse generator stop logic
module acu_axis_model
   import acu_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // counter setting
   input  wire logic [31:0] val,
   input  wire logic        up,
   // block side
   input  wire acu_req_s    req,
   input  wire logic        sync,
   output acu_cnt_s         cnt,
   // request tallies
   output int               n_stop,
   output int               n_decel,
   output int               n_bulk,
   output int               n_sync
);
   ////////////////////////////////////////////////////////////////////////////////
   // distinct per target, except counter_one, counter_four and counter 3 (magnitude of -val), which all give val
   // so a wrong target select shows up as a wrong result
   always_comb
   begin
      cnt.counter_one       = val;
      cnt.counter_two       = ~val;
      cnt.deviation_counter = -val;
      cnt.counter_four      = val;
      cnt.remaining_pulses  = val << 1;
      cnt.current_speed     = val << 2;
      cnt.count_up          = up;
      cnt.count_down        = !up;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // pulses counted per cycle
   // a level held high would count once per cycle, not once per event
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         n_stop  <= 0;
         n_decel <= 0;
         n_bulk  <= 0;
         n_sync  <= 0;
      end
      else
      begin
         n_stop  <= n_stop + int'(req.stop_now);
         n_decel <= n_decel + int'(req.stop_decel);
         n_bulk  <= n_bulk + int'(req.bulk_override);
         n_sync  <= n_sync + int'(sync);
      end
   end
endmodule : acu_axis_model

// [acu_pkg.sv]
package acu_pkg;
   // register byte addresses on the bus
   localparam logic [7:0] ACU_PINCFG_ADDR = 8'h00;
   localparam logic [7:0] ACU_CFGA_ADDR   = 8'h04;
   localparam logic [7:0] ACU_CFGB_ADDR   = 8'h08;
   localparam logic [7:0] ACU_IRQEN_ADDR  = 8'h0c;
   localparam logic [7:0] ACU_CAUSE_ADDR  = 8'h10;
   localparam logic [7:0] ACU_MAIN_STATUS_ADDR   = 8'h14;
   localparam logic [7:0] ACU_ERR_ADDR    = 8'h18;
   localparam logic [7:0] ACU_CMPV_ADDR   = 8'h20; // compare values 1..5, one word each
   // reset values
   localparam logic [31:0] ACU_CFG_RST = 32'h0000_0000;
   // field positions, compare_config_a (per comparator step of 8 bits, cmp 1..3)
   localparam int ACU_TGT_LSB  = 0;
   localparam int ACU_COND_LSB = 2;
   localparam int ACU_ACT_LSB  = 5;
   localparam int ACU_CMP_STEP = 8;
   localparam int ACU_C4C_LSB  = 24;
   localparam int ACU_C4S_LSB  = 26;
   localparam int ACU_C4D_LSB  = 30;
   // compare_config_b
   localparam int ACU_C5C_LSB  = 0;
   localparam int ACU_C5S_LSB  = 3;
   localparam int ACU_C5D_LSB  = 6;
   localparam int ACU_SYO_LSB  = 16;
   localparam int ACU_INDEX_COMPARE_MODE_BIT = 20;
   // pin_function_config, pins 3..7 two bits each
   localparam int ACU_PFN_LSB  = 6;
   // status, enable and cause bit base
   localparam int ACU_CMP_BIT  = 8;
   // condition codes
   localparam logic [3:0] ACU_C_EQ     = 4'h1;
   localparam logic [3:0] ACU_C_EQUP   = 4'h2;
   localparam logic [3:0] ACU_C_EQDN   = 4'h3;
   localparam logic [3:0] ACU_C_GT     = 4'h4;
   localparam logic [3:0] ACU_C_LT     = 4'h5;
   localparam logic [3:0] ACU_C_SLIM   = 4'h6;
   localparam logic [3:0] ACU_C_IDX    = 4'h8;
   localparam logic [3:0] ACU_C_IDXUP  = 4'h9;
   localparam logic [3:0] ACU_C_IDXDN  = 4'ha;
   // action codes
   localparam logic [1:0] ACU_A_NONE   = 2'h0;
   localparam logic [1:0] ACU_A_STOP   = 2'h1;
   localparam logic [1:0] ACU_A_DECEL  = 2'h2;
   localparam logic [1:0] ACU_A_BULK   = 2'h3;
   // target selects for counter 3 and beyond the four counters
   localparam logic [2:0] ACU_T_CNT3   = 3'h2;
   localparam logic [2:0] ACU_T_REM    = 3'h4;
   localparam logic [2:0] ACU_T_SPEED  = 3'h5;
   // counter values and count direction from the axis
   typedef struct packed {
      logic [31:0] counter_one;
      logic [31:0] counter_two;
      logic [31:0] deviation_counter;
      logic [31:0] counter_four;
      logic [31:0] remaining_pulses;
      logic [31:0] current_speed;
      logic        count_up;
      logic        count_down;
   } acu_cnt_s;
   // single-cycle action requests to the pulse generator
   typedef struct packed {
      logic stop_now;
      logic stop_decel;
      logic bulk_override;
   } acu_req_s;
endpackage : acu_pkg

// [acu_top.sv]
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - codes 001/010/011 detect equality any direction, counting up, counting down.
// - code 100 means compare value above target, 101 means below.
// - code 000 and unassigned codes never satisfy the comparator.
// - comparator 1 code 110 is plus limit: compare value below counter one.
// - comparator 2 code 110 is minus limit: compare value above counter one.
// - comparator 4 has a four-bit condition at 29:26, codes 1-5 as others.
// - comparator 4 codes 1000/1001/1010 drive index output: any, up, down.
// - two-bit action: none, immediate stop, deceleration stop, bulk override.
// - comparator 5 action sits at bits 7:6 of compare_config_b.
// - comparator 1 limit code forces immediate stop for action none or bulk.
// - comparator 2 limit code forces immediate stop for action none or bulk.
// - no action still drives interrupt, compare pin and sync trigger.
// - main status bits 8..12 show each comparator satisfied.
// - enable bits 8..12 raise event interrupt on status rising.
// - cause bits 8..12 set when status rises.
// - pins 3..7 show compare state, code 10 active low, 11 active high.
// - sync select 1..5 triggers sync pulse on comparator 1..5 rising.
// - five independent 32-bit comparators per axis.
// - targets counters 1..4; comparator 5 adds remaining pulses, speed; counter3 absolute.
// - comparator 5 target 100 remaining pulses, 101 current speed.
// - stop by comparator 1 or 2 sets its error cause bit.
module acu_top
   import acu_pkg::*;
#(
   parameter int NCMP = 5
)(
   // clock and reset
   input  wire logic              CLK,
   input  wire logic              RST_N,
   // ahb-lite slave
   input  wire logic              HSEL,
   input  wire logic [31:0]       HADDR,
   input  wire logic [1:0]        HTRANS,
   input  wire logic              HWRITE,
   input  wire logic [2:0]        HSIZE,
   input  wire logic [31:0]       HWDATA,
   input  wire logic              HREADY,
   output logic                   HREADYOUT,
   output logic [31:0]            HRDATA,
   output logic                   HRESP,
   // axis counters, same clock
   input  wire acu_cnt_s          CNT,
   // requests and signals to the axis
   output acu_req_s               REQ,
   output logic                   EVENT_IRQ,
   output logic                   SYNC_TRIG,
   output logic                   INDEX_PULSE_OUT,
   // general pins 3..7
   output logic [NCMP-1:0]        GP_OUT,
   output logic [NCMP-1:0]        GP_OE_N
);

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   logic [31:0]      pin_function_config_r;
   logic [31:0]      compare_config_a_r;
   logic [31:0]      compare_config_b_r;
   logic [NCMP-1:0]  event_irq_enable_r;
   logic [NCMP-1:0]  event_irq_cause_r;
   logic [NCMP-1:0]  event_irq_cause_nxt;
   logic [1:0]       error_cause_r;
   logic [1:0]       error_cause_nxt;
   logic [31:0]      compare_value_r [NCMP];
   logic [NCMP-1:0]  met_r;
   logic [NCMP-1:0]  met_nxt;
   logic [NCMP-1:0]  rise;
   logic [3:0]       cond   [NCMP];
   logic [1:0]       action [NCMP];
   logic [2:0]       tsel   [NCMP];
   logic [31:0]      target [NCMP];
   logic [31:0]      dev_abs;
   logic             idx_mode;
   acu_req_s         req_nxt;
   logic [1:0]       err_set;
   // bus pipeline
   logic             wr_pend_r;
   logic [7:0]       wr_addr_r;
   logic             addr_ph;
   logic             wr_hit;

   ////////////////////////////////////////////////////////////////////////////////
   // field extraction
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         cond[i]   = {1'b0, compare_config_a_r[ACU_CMP_STEP*i+ACU_COND_LSB +: 3]};
         action[i] = compare_config_a_r[ACU_CMP_STEP*i+ACU_ACT_LSB +: 2];
         tsel[i]   = {1'b0, compare_config_a_r[ACU_CMP_STEP*i+ACU_TGT_LSB +: 2]};
      end
      cond[3]   = compare_config_a_r[ACU_C4S_LSB +: 4];
      action[3] = compare_config_a_r[ACU_C4D_LSB +: 2];
      tsel[3]   = {1'b0, compare_config_a_r[ACU_C4C_LSB +: 2]};
      cond[4]   = {1'b0, compare_config_b_r[ACU_C5S_LSB +: 3]};
      action[4] = compare_config_b_r[ACU_C5D_LSB +: 2];
      tsel[4]   = compare_config_b_r[ACU_C5C_LSB +: 3];
   end

   assign idx_mode = compare_config_b_r[ACU_INDEX_COMPARE_MODE_BIT];
   // counter 3 holds a signed deviation, compared by magnitude
   assign dev_abs  = CNT.deviation_counter[31] ? 32'h0 - CNT.deviation_counter
                                               : CNT.deviation_counter;

   always_comb
   begin
      for (int i = 0; i < NCMP; i++)
      begin
         case (tsel[i])
            3'h0:        target[i] = CNT.counter_one;
            3'h1:        target[i] = CNT.counter_two;
            ACU_T_CNT3:  target[i] = dev_abs;
            3'h3:        target[i] = CNT.counter_four;
            ACU_T_REM:   target[i] = CNT.remaining_pulses;
            ACU_T_SPEED: target[i] = CNT.current_speed;
            default:     target[i] = 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // condition evaluation, shared by all comparators
   function automatic logic acu_eval(input logic [3:0] code, input int idx,
                                     input logic [31:0] cv, input logic [31:0] tg,
                                     input logic [31:0] c1, input logic up,
                                     input logic dn, input logic im);
      logic eq;
      logic signed [31:0] scv;
      logic signed [31:0] stg;
      scv = $signed(cv);
      stg = $signed(tg);
      eq  = (cv == tg);
      case (code)
         ACU_C_EQ:    acu_eval = eq;
         ACU_C_EQUP:  acu_eval = eq & up;
         ACU_C_EQDN:  acu_eval = eq & dn;
         ACU_C_GT:    acu_eval = scv > stg;
         ACU_C_LT:    acu_eval = scv < stg;
         ACU_C_SLIM:  acu_eval = (idx == 0) ? (scv < $signed(c1)) :
                                 (idx == 1) ? (scv > $signed(c1)) : 1'b0;
         // index codes, comparator 4 only; mode 1 compares magnitude
         ACU_C_IDX:   acu_eval = (idx == 3) & (im ? (cv == (stg < 0 ? -tg : tg)) : eq);
         ACU_C_IDXUP: acu_eval = (idx == 3) & up & (im ? (cv == (stg < 0 ? -tg : tg)) : eq);
         ACU_C_IDXDN: acu_eval = (idx == 3) & dn & (im ? (cv == (stg < 0 ? -tg : tg)) : eq);
         default:     acu_eval = 1'b0;
      endcase
   endfunction : acu_eval

   always_comb
   begin
      for (int i = 0; i < NCMP; i++)
      begin
         met_nxt[i] = acu_eval(cond[i], i, compare_value_r[i], target[i], CNT.counter_one,
                               CNT.count_up, CNT.count_down, idx_mode);
      end
   end

   assign rise = met_nxt & ~met_r;

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         met_r <= '0;
      else
         met_r <= met_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // action requests
   always_comb
   begin
      req_nxt = '0;
      err_set = '0;
      for (int i = 0; i < NCMP; i++)
      begin
         if (rise[i])
         begin
            // limit code turns none and bulk into an immediate stop
            // a deceleration stop stays a deceleration stop, past the limit point
            if (i < 2 && cond[i] == ACU_C_SLIM &&
                (action[i] == ACU_A_NONE || action[i] == ACU_A_BULK))
               req_nxt.stop_now = 1'b1;
            else
            begin
               case (action[i])
                  ACU_A_STOP:  req_nxt.stop_now      = 1'b1;
                  ACU_A_DECEL: req_nxt.stop_decel    = 1'b1;
                  ACU_A_BULK:  req_nxt.bulk_override = 1'b1;
                  default:     ;
               endcase
            end
            // stops caused by comparators 1 and 2
            if (i < 2 && (cond[i] == ACU_C_SLIM || action[i] == ACU_A_STOP ||
                          action[i] == ACU_A_DECEL))
               err_set[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         REQ <= '0;
      else
         REQ <= req_nxt;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         SYNC_TRIG <= 1'b0;
      else
         SYNC_TRIG <= (compare_config_b_r[ACU_SYO_LSB +: 4] inside {[4'h1:4'h5]}) &&
                      rise[compare_config_b_r[ACU_SYO_LSB +: 3] - 3'h1];
   end

   // index output follows comparator 4 under index codes
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         INDEX_PULSE_OUT <= 1'b0;
      else
         INDEX_PULSE_OUT <= cond[3][3] & met_nxt[3];
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         GP_OUT  <= '0;
         GP_OE_N <= '1;
      end
      else
      begin
         for (int i = 0; i < NCMP; i++)
         begin
            GP_OUT[i]  <= pin_function_config_r[ACU_PFN_LSB+2*i] ? met_nxt[i] : ~met_nxt[i];
            GP_OE_N[i] <= ~pin_function_config_r[ACU_PFN_LSB+2*i+1];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sticky causes; a set in the cycle of a clear wins
   always_comb
   begin
      event_irq_cause_nxt = event_irq_cause_r;
      error_cause_nxt     = error_cause_r;
      if (wr_hit && wr_addr_r == ACU_CAUSE_ADDR)
         event_irq_cause_nxt = event_irq_cause_r & ~HWDATA[ACU_CMP_BIT +: NCMP];
      if (wr_hit && wr_addr_r == ACU_ERR_ADDR)
         error_cause_nxt = error_cause_r & ~HWDATA[1:0];
      event_irq_cause_nxt = event_irq_cause_nxt | rise;
      error_cause_nxt     = error_cause_nxt | err_set;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         event_irq_cause_r <= '0;
         error_cause_r     <= '0;
         EVENT_IRQ         <= 1'b0;
      end
      else
      begin
         event_irq_cause_r <= event_irq_cause_nxt;
         error_cause_r     <= error_cause_nxt;
         // enabled causes drive the event line
         EVENT_IRQ         <= |(event_irq_cause_nxt & event_irq_enable_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave, zero wait states, always okay
   assign addr_ph = HSEL & HTRANS[1] & HREADY;
   assign wr_hit  = wr_pend_r & HREADY;

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
      else
      begin
         if (HREADY)
         begin
            wr_pend_r <= addr_ph & HWRITE;
            wr_addr_r <= HADDR[7:0];
         end
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
   end

   // read data sampled at the address phase; unmapped reads give zero
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         HRDATA <= '0;
      else if (addr_ph && !HWRITE)
      begin
         HRDATA <= '0;
         case (HADDR[7:0])
            ACU_PINCFG_ADDR: HRDATA <= pin_function_config_r;
            ACU_CFGA_ADDR:   HRDATA <= compare_config_a_r;
            ACU_CFGB_ADDR:   HRDATA <= compare_config_b_r;
            ACU_IRQEN_ADDR:  HRDATA[ACU_CMP_BIT +: NCMP] <= event_irq_enable_r;
            ACU_CAUSE_ADDR:  HRDATA[ACU_CMP_BIT +: NCMP] <= event_irq_cause_r;
            ACU_MAIN_STATUS_ADDR:   HRDATA[ACU_CMP_BIT +: NCMP] <= met_r;
            ACU_ERR_ADDR:    HRDATA[1:0] <= error_cause_r;
            default:
            begin
               for (int i = 0; i < NCMP; i++)
                  if (HADDR[7:0] == ACU_CMPV_ADDR + 8'(4*i))
                     HRDATA <= compare_value_r[i];
            end
         endcase
      end
   end

   // configuration writes in the data phase
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         pin_function_config_r <= ACU_CFG_RST;
         compare_config_a_r    <= ACU_CFG_RST;
         compare_config_b_r    <= ACU_CFG_RST;
         event_irq_enable_r    <= '0;
         for (int i = 0; i < NCMP; i++)
            compare_value_r[i] <= ACU_CFG_RST;
      end
      else if (wr_hit)
      begin
         case (wr_addr_r)
            ACU_PINCFG_ADDR: pin_function_config_r <= HWDATA;
            ACU_CFGA_ADDR:   compare_config_a_r    <= HWDATA;
            ACU_CFGB_ADDR:   compare_config_b_r    <= HWDATA;
            ACU_IRQEN_ADDR:  event_irq_enable_r    <= HWDATA[ACU_CMP_BIT +: NCMP];
            default:
            begin
               for (int i = 0; i < NCMP; i++)
                  if (wr_addr_r == ACU_CMPV_ADDR + 8'(4*i))
                     compare_value_r[i] <= HWDATA;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   chk_eq_up_only: assert property (@(posedge CLK) disable iff (!RST_N)
      (cond[2] == ACU_C_EQUP && !CNT.count_up) |=> !met_r[2])
      else $error("equality-up satisfied while not counting up");
   chk_gt_match: assert property (@(posedge CLK) disable iff (!RST_N)
      (cond[2] == ACU_C_GT && $signed(compare_value_r[2]) > $signed(target[2])) |=> met_r[2])
      else $error("greater-than condition missed");
   chk_never_met: assert property (@(posedge CLK) disable iff (!RST_N)
      (cond[0] == 4'h0) |=> !met_r[0])
      else $error("code zero satisfied");
   chk_plus_limit: assert property (@(posedge CLK) disable iff (!RST_N)
      (rise[0] && cond[0] == ACU_C_SLIM && (action[0] == ACU_A_NONE || action[0] == ACU_A_BULK))
      |=> REQ.stop_now && error_cause_r[0])
      else $error("plus limit gave no immediate stop");
   chk_index_eq: assert property (@(posedge CLK) disable iff (!RST_N)
      (cond[3] == ACU_C_IDX && !idx_mode && compare_value_r[3] == target[3])
      |=> INDEX_PULSE_OUT && met_r[3])
      else $error("index output missing");
   chk_cause_rise: assert property (@(posedge CLK) disable iff (!RST_N)
      (met_r == '0) ##1 (met_r[4]) |-> event_irq_cause_r[4])
      else $error("cause not set on rise");
   chk_irq_raise: assert property (@(posedge CLK) disable iff (!RST_N)
      (rise[2] && event_irq_enable_r[2]) |=> EVENT_IRQ)
      else $error("enabled rise gave no interrupt");
   chk_pin_high: assert property (@(posedge CLK) disable iff (!RST_N)
      (pin_function_config_r[ACU_PFN_LSB +: 2] == 2'h3) |=> (GP_OUT[0] == met_r[0]) && !GP_OE_N[0])
      else $error("active-high pin wrong");
   chk_sync_sel: assert property (@(posedge CLK) disable iff (!RST_N)
      (compare_config_b_r[ACU_SYO_LSB +: 4] == 4'h3 && rise[2]) |=> SYNC_TRIG)
      else $error("sync trigger missing");
   chk_decel_err: assert property (@(posedge CLK) disable iff (!RST_N)
      (rise[1] && cond[1] != ACU_C_SLIM && action[1] == ACU_A_DECEL)
      |=> REQ.stop_decel && error_cause_r[1])
      else $error("decel stop or error cause missing");

endmodule : acu_top

// [axis_compare_unit_bench.sv]
`timescale 1ns/1ps
module axis_compare_unit_bench import acu_pkg::*;;
   // bus, pins and bench state
   logic        CLK = 0, RST_N = 0, HSEL = 0, HWRITE = 0, u = 1;
   logic [31:0] HADDR = 0, HWDATA = 0, v = 0, q, HRDATA;
   logic [1:0]  HTRANS = 0;
   logic [2:0]  HSIZE = 3'h2;
   logic        HREADYOUT, HRESP, EVENT_IRQ, SYNC_TRIG, INDEX_PULSE_OUT;
   logic [4:0]  GP_OUT, GP_OE_N;
   acu_cnt_s    CNT;
   acu_req_s    REQ;
   int          fails = 0, total_checks = 0, cyc = 0, ns, nd, nb, ny;
   int          n_stop, n_decel, n_bulk, n_sync;
   ////////////////////////////////////////////////////////////////////////////////
   // 10 mhz clock
   always #50 CLK = ~CLK;
   acu_top i_acu_top (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
      .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
      .CNT(CNT), .REQ(REQ), .EVENT_IRQ(EVENT_IRQ), .SYNC_TRIG(SYNC_TRIG),
      .INDEX_PULSE_OUT(INDEX_PULSE_OUT), .GP_OUT(GP_OUT), .GP_OE_N(GP_OE_N));
   acu_axis_model i_acu_axis_model (.clk(CLK), .rst_n(RST_N), .val(v), .up(u),
      .req(REQ), .sync(SYNC_TRIG), .cnt(CNT), .n_stop(n_stop), .n_decel(n_decel),
      .n_bulk(n_bulk), .n_sync(n_sync));
   ////////////////////////////////////////////////////////////////////////////////
   // one single ahb-lite transfer, entered just after a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      HSEL   <= 1'b1;
      HTRANS <= 2'b10;
      HADDR  <= {24'h0, a};
      HWRITE <= w;
      @(posedge CLK);
      while (HREADYOUT !== 1'b1) @(posedge CLK);
      HSEL   <= 1'b0;
      HTRANS <= 2'b00;
      HWDATA <= d;
      @(posedge CLK);
      while (HREADYOUT !== 1'b1) @(posedge CLK);
      q = HRDATA;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask : rd
   task automatic tk(input int n);
      repeat (n) @(posedge CLK);
   endtask : tk
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // expected satisfaction of a three-bit condition code, signed compare
   function automatic logic met(input int c, input int cv, input int tg, input logic up);
      case (c)
         1: return cv == tg;
         2: return cv == tg && up;
         3: return cv == tg && !up;
         4: return cv > tg;
         5: return cv < tg;
         default: return 1'b0;
      endcase
   endfunction : met
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////////////////////////
   // hang guard, the whole run needs well under a thousand cycles
   always @(posedge CLK)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         fails++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      repeat (3) @(posedge CLK);
      RST_N <= 1'b1;
      @(posedge CLK);
      rd(ACU_CFGA_ADDR);
      chk("cfg a reset", q, ACU_CFG_RST);
      rd(8'h40);
      chk("unmapped", q, 32'h0);
      chk("bus okay", 32'(HRESP), 32'h0);
      chk("pins undriven", 32'(GP_OE_N), 32'h1f);
      $display("test reset done");
      // every permitted three-bit code on comparator 3 against counter one, both directions
      wr(ACU_CMPV_ADDR + 8'h08, 32'd10);
      for (int k = 0; k < 48; k++)
      begin
         int c;
         // code 110 is not for comparator 3, code 111 stands in for it
         c = (k % 8 == 6) ? 7 : k % 8;
         v <= 9 + (k / 8) % 3;
         u <= k < 24;
         wr(ACU_CFGA_ADDR, 32'(c) << (ACU_COND_LSB + 16));
         tk(2);
         rd(ACU_MAIN_STATUS_ADDR);
         chk("cmp3 met", q[10], met(c, 10, 9 + (k / 8) % 3, k < 24));
      end
      $display("test conditions done");
      // comparator 5 on remaining pulses (twice the value), then on speed (four times)
      v <= 10;
      u <= 1'b1;
      wr(ACU_CMPV_ADDR + 8'h10, 32'd20);
      for (int t = 4; t < 6; t++)
      begin
         wr(ACU_CFGB_ADDR, 32'(t) | (32'h1 << ACU_C5S_LSB));
         tk(2);
         rd(ACU_MAIN_STATUS_ADDR);
         chk("cmp5 target", q[12], t == 4);
      end
      // comparator 4 index codes against counter four, up and down with absolute mode, any without
      wr(ACU_CMPV_ADDR + 8'h0c, 32'd10);
      wr(ACU_CFGB_ADDR, 32'h1 << ACU_INDEX_COMPARE_MODE_BIT);
      wr(ACU_CFGA_ADDR, 32'({ACU_C_IDXUP, 2'h3}) << ACU_C4C_LSB);
      tk(2);
      chk("index up", INDEX_PULSE_OUT, 1'b1);
      wr(ACU_CFGA_ADDR, 32'({ACU_C_IDXDN, 2'h3}) << ACU_C4C_LSB);
      tk(2);
      chk("index down", INDEX_PULSE_OUT, 1'b0);
      wr(ACU_CFGB_ADDR, 32'h0);
      wr(ACU_CFGA_ADDR, 32'({ACU_C_IDX, 2'h3}) << ACU_C4C_LSB);
      tk(2);
      chk("index any", INDEX_PULSE_OUT, 1'b1);
      v <= 11;
      wr(ACU_CFGA_ADDR, 32'({ACU_C_LT, 2'h0}) << ACU_C4C_LSB);
      tk(2);
      rd(ACU_MAIN_STATUS_ADDR);
      chk("cmp4 less", q[11], 1'b1);
      $display("test targets done");
      // each action on comparator 3, with pin 5 active low, sync and interrupt
      wr(ACU_PINCFG_ADDR, (32'h2 << (ACU_PFN_LSB + 4)) | (32'h3 << ACU_PFN_LSB));
      wr(ACU_CFGB_ADDR, 32'h3 << ACU_SYO_LSB);
      wr(ACU_IRQEN_ADDR, 32'h1 << 10);
      for (int a = 0; a < 4; a++)
      begin
         v <= 0;
         wr(ACU_CFGA_ADDR, 32'((a << ACU_ACT_LSB) | (1 << ACU_COND_LSB)) << 16);
         wr(ACU_CAUSE_ADDR, 32'h1f00);
         tk(2);
         chk("irq cleared", EVENT_IRQ, 1'b0);
         chk("pin idle", GP_OUT[2], 1'b1);
         chk("pin driven", GP_OE_N[2], 1'b0);
         ns = n_stop;
         nd = n_decel;
         nb = n_bulk;
         ny = n_sync;
         v <= 10;
         tk(3);
         chk("pin active", GP_OUT[2], 1'b0);
         chk("irq raised", EVENT_IRQ, 1'b1);
         chk("stop now", n_stop - ns, a == 1);
         chk("stop decel", n_decel - nd, a == 2);
         chk("bulk", n_bulk - nb, a == 3);
         chk("sync", n_sync - ny, 1);
      end
      wr(ACU_IRQEN_ADDR, 32'h0);
      v <= 0;
      tk(2);
      wr(ACU_CAUSE_ADDR, 32'h1f00);
      v <= 10;
      tk(3);
      chk("irq masked", EVENT_IRQ, 1'b0);
      rd(ACU_CAUSE_ADDR);
      chk("cause kept", q[10], 1'b1);
      $display("test actions done");
      // software limits: minus side with bulk action, plus side with no action
      v <= 5;
      wr(ACU_CMPV_ADDR, 32'd5);
      wr(ACU_CMPV_ADDR + 8'h04, 32'd5);
      wr(ACU_CFGA_ADDR, 32'h0000_7818);
      wr(ACU_ERR_ADDR, 32'h3);
      tk(2);
      ns = n_stop;
      v <= 4;
      tk(3);
      chk("minus limit", n_stop - ns, 1);
      rd(ACU_ERR_ADDR);
      chk("error minus", q[1:0], 2'h2);
      v <= 6;
      tk(3);
      chk("plus limit", n_stop - ns, 2);
      chk("pin 3 high", GP_OUT[0], 1'b1);
      rd(ACU_ERR_ADDR);
      chk("error both", q[1:0], 2'h3);
      $display("test limits done");
      wrap_up();
   end
endmodule : axis_compare_unit_bench
